// ==== common/sd_link_params.svh ====
`ifndef SD_LINK_PARAMS_SVH
`define SD_LINK_PARAMS_SVH

// System clock and modulator clock limits
`define SYS_CLK_HZ          40000000
`define MOD_CLK_MAX_HZ      20000000
`define MOD_CLK_MIN_HZ      5000000
// Least divide ratio, rounded up so the modulator clock never exceeds its maximum
`define MOD_CLK_DIV_MIN     ((`SYS_CLK_HZ + `MOD_CLK_MAX_HZ - 1) / `MOD_CLK_MAX_HZ)
// Largest divide ratio, rounded down so the modulator clock never drops below its minimum
`define MOD_CLK_DIV_MAX     (`SYS_CLK_HZ / `MOD_CLK_MIN_HZ)

// Analog input scale in millivolts
`define INPUT_FULL_SCALE_MV 320
`define INPUT_WIDTH         16
`define MOD_INTEG_WIDTH     24
// Modulator integrator limits, in multiples of full scale
`define MOD_INTEG_A_SPAN    8
`define MOD_INTEG_B_SPAN    32

// Decimation filter
`define FILTER_ORDER        3
`define DECIM_RATIO         256
`define OUT_BITS            16
`define SETTLE_WORDS        3
`define CODE_MAX            16'hffff

`endif

// ==== common/sd_link_pkg.sv ====
`default_nettype none
`include "sd_link_params.svh"

package sd_link_pkg;

	typedef logic        [`OUT_BITS-1:0]    sample_t;
	typedef logic signed [`INPUT_WIDTH-1:0] diff_mv_t;

endpackage

`default_nettype wire

// ==== common/sd_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface sd_link_if;

	logic modulator_clock_in;
	logic modulator_bitstream_out;

	modport modulator_end
	(
		input  modulator_clock_in,
		output modulator_bitstream_out
	);

	modport filter_end
	(
		output modulator_clock_in,
		input  modulator_bitstream_out
	);

endinterface

`default_nettype wire

// ==== rtl/sd_modulator_end.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sd_link_params.svh"

module sd_modulator_end
	import sd_link_pkg::*;
(
	input  wire logic            clk_sys_i, // System clock, 40 MHz
	input  wire logic            rst_n_i,   // Asynchronous reset, active low
	sd_link_if.modulator_end     link,      // Modulator clock in, bit stream out
	input  wire diff_mv_t        diff_mv_i  // Differential input in millivolts, signed
);

	localparam int IW = `MOD_INTEG_WIDTH;
	localparam logic signed [IW-1:0] FS = IW'(`INPUT_FULL_SCALE_MV);
	localparam logic signed [IW-1:0] A_LIM = IW'(`MOD_INTEG_A_SPAN * `INPUT_FULL_SCALE_MV);
	localparam logic signed [IW-1:0] B_LIM = IW'(`MOD_INTEG_B_SPAN * `INPUT_FULL_SCALE_MV);

	logic                 clk_q;
	logic                 stream_bit;
	logic signed [IW-1:0] integ_a;
	logic signed [IW-1:0] integ_b;
	logic signed [IW-1:0] x_in;
	logic signed [IW-1:0] fb;
	logic signed [IW-1:0] next_integ_a;
	logic signed [IW-1:0] next_integ_b;
	logic                 clk_rise;

	// Symmetric limiter shared by the input and both integrators
	function automatic logic signed [IW-1:0] limit(input logic signed [IW-1:0] w, input logic signed [IW-1:0] lim);
		if (w > lim)
			limit = lim;
		else if (w < -lim)
			limit = -lim;
		else
			limit = w;
	endfunction

	assign clk_rise = link.modulator_clock_in & ~clk_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			clk_q <= 1'b0;
		else
			clk_q <= link.modulator_clock_in;
	end

	// Second order loop: density of ones tracks (x + FS) / (2 FS)
	always_comb
	begin
		// Inputs beyond full scale would only wind up the loop; hold them at the rail
		x_in         = limit(IW'(diff_mv_i), FS);
		fb           = stream_bit ? FS : -FS;
		// Held at full scale, an unlimited integrator would grow until it wraps and flips the stream
		next_integ_a = limit(integ_a + x_in - fb, A_LIM);
		next_integ_b = limit(integ_b + integ_a - (fb <<< 1), B_LIM);
	end

	// Only the far party's clock advances the loop, so the bit rate is its rate
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			integ_a    <= '0;
			integ_b    <= '0;
			stream_bit <= 1'b0;
		end
		else if (clk_rise)
		begin
			integ_a    <= next_integ_a;
			integ_b    <= next_integ_b;
			stream_bit <= ~next_integ_b[IW-1];
		end
	end

	assign link.modulator_bitstream_out = stream_bit;

endmodule // sd_modulator_end

`default_nettype wire

// ==== rtl/sd_decimator_end.sv ====
// Overview of operation
// - Device emits ones density stream, max 20 MHz
// - This end supplies the modulator clock
// - Zero input gives half ones
// - Plus/minus 250 mV give 89.06/10.94 percent
// - Plus/minus 320 mV give all ones/zeros
// - Filter and decimate with sinc3
// - Ratio 256 at 20 MHz gives 78.1 kSPS
// - Minus/plus 250 mV map to 7168/58368
// - Zero input maps to code 32768
// - Launch on rising edge, capture next rising
// - Keep modulator clock within 5 to 20 MHz
// - Sixteen top bits of grown word form result
// - One word per ratio count of clocks
`timescale 1ns/100ps
`default_nettype none
`include "sd_link_params.svh"

module sd_decimator_end
	import sd_link_pkg::*;
#(
	parameter int MOD_CLK_DIV = `MOD_CLK_DIV_MIN, // System clocks per modulator clock, even
	parameter int DECIM_RATIO = `DECIM_RATIO      // Power of two
)
(
	input  wire logic   clk_sys_i,      // System clock, 40 MHz
	input  wire logic   rst_n_i,        // Asynchronous reset, active low
	sd_link_if.filter_end link,         // Modulator clock out, bit stream in
	output var sample_t sample_o,       // Filtered 16-bit code, offset binary
	output var logic    sample_valid_o, // Sample holds a word
	input  wire logic   sample_ready_i  // Consumer takes the word
);

	localparam int ORDER  = `FILTER_ORDER;
	localparam int LOG2DR = $clog2(DECIM_RATIO);
	localparam int GROWTH = ORDER * LOG2DR;
	localparam int ACC_W  = GROWTH + 2;
	localparam int SHIFT  = GROWTH + 1 - `OUT_BITS;
	localparam int HALF   = MOD_CLK_DIV / 2;
	localparam int HALF_W = (HALF > 1) ? $clog2(HALF) : 1;

	localparam logic [LOG2DR-1:0] DEC_LAST   = LOG2DR'(DECIM_RATIO - 1);
	localparam logic [HALF_W-1:0] HALF_LAST  = HALF_W'(HALF - 1);
	localparam logic [1:0]        SETTLE_END = 2'(`SETTLE_WORDS);
	localparam logic [ACC_W-1:0]  GAIN       = ACC_W'(1) << GROWTH;

	typedef logic signed [ACC_W-1:0] acc_t;

	// Divider limits; a ratio outside them would breach the modulator clock range
	initial
	begin
		if (MOD_CLK_DIV < `MOD_CLK_DIV_MIN || MOD_CLK_DIV > `MOD_CLK_DIV_MAX || (MOD_CLK_DIV % 2) != 0)
			$error("Modulator clock divider out of range");
	end

	logic              mod_clk;
	logic [HALF_W-1:0] half_cnt;
	logic              stall;
	logic              rise_now;
	logic [LOG2DR-1:0] dec_cnt;
	logic              dec_done;
	acc_t              integ [ORDER];
	acc_t              delay [ORDER];
	acc_t              comb  [ORDER];
	acc_t              step;
	logic [1:0]        settle_cnt;
	sample_t           next_code;
	logic              push;
	logic              pop;
	sample_t           slot [2];
	logic              slot_vld [2];

	// Offset binary with the top code clipped: full-scale ones would wrap to zero
	function automatic sample_t to_code(input acc_t sum);
		logic [ACC_W-1:0] biased;
		logic [ACC_W-1:0] shifted;
		biased  = ACC_W'(sum) + GAIN;
		shifted = biased >> SHIFT;
		if (shifted > ACC_W'(`CODE_MAX))
			to_code = `CODE_MAX;
		else
			to_code = shifted[`OUT_BITS-1:0];
	endfunction

	// A full buffer stops the modulator clock, so no word is ever dropped
	assign stall    = slot_vld[1];
	assign rise_now = !stall && (half_cnt == HALF_LAST) && !mod_clk;
	assign dec_done = rise_now && (dec_cnt == DEC_LAST);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			half_cnt <= '0;
			mod_clk  <= 1'b0;
		end
		else if (!stall)
		begin
			if (half_cnt == HALF_LAST)
			begin
				half_cnt <= '0;
				mod_clk  <= ~mod_clk;
			end
			else
				half_cnt <= half_cnt + 1'b1;
		end
	end

	assign link.modulator_clock_in = mod_clk;

	// The bit seen at a rising edge was launched at the previous one
	assign step = link.modulator_bitstream_out ? acc_t'(1) : -acc_t'(1);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < ORDER; i++)
				integ[i] <= '0;
		end
		else if (rise_now)
		begin
			integ[0] <= integ[0] + step;
			for (int i = 1; i < ORDER; i++)
				integ[i] <= integ[i] + integ[i-1];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dec_cnt <= '0;
		else if (rise_now)
			dec_cnt <= dec_cnt + 1'b1;
	end

	// Wrapping arithmetic is safe: the comb differences undo any integrator overflow
	always_comb
	begin
		comb[0] = integ[ORDER-1] - delay[0];
		for (int i = 1; i < ORDER; i++)
			comb[i] = comb[i-1] - delay[i];
		next_code = to_code(comb[ORDER-1]);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < ORDER; i++)
				delay[i] <= '0;
		end
		else if (dec_done)
		begin
			delay[0] <= integ[ORDER-1];
			for (int i = 1; i < ORDER; i++)
				delay[i] <= comb[i-1];
		end
	end

	// The comb chain holds start-up garbage until three full periods have passed
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			settle_cnt <= '0;
		else if (dec_done && settle_cnt != SETTLE_END)
			settle_cnt <= settle_cnt + 1'b1;
	end

	assign push = dec_done && (settle_cnt == SETTLE_END);
	assign pop  = slot_vld[0] && sample_ready_i;

	// Two-slot shift buffer; slot 0 is the head so the outputs come from flip-flops
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			slot[0]     <= '0;
			slot[1]     <= '0;
			slot_vld[0] <= 1'b0;
			slot_vld[1] <= 1'b0;
		end
		else
		begin
			unique case ({push, pop})
				2'b11:
				begin
					if (slot_vld[1])
					begin
						slot[0] <= slot[1];
						slot[1] <= next_code;
					end
					else
						slot[0] <= next_code;
				end
				2'b01:
				begin
					slot[0]     <= slot[1];
					slot_vld[0] <= slot_vld[1];
					slot_vld[1] <= 1'b0;
				end
				2'b10:
				begin
					if (!slot_vld[0])
					begin
						slot[0]     <= next_code;
						slot_vld[0] <= 1'b1;
					end
					else
					begin
						slot[1]     <= next_code;
						slot_vld[1] <= 1'b1;
					end
				end
				2'b00:
				begin
				end
			endcase
		end
	end

	assign sample_o       = slot[0];
	assign sample_valid_o = slot_vld[0];

endmodule // sd_decimator_end

`default_nettype wire

// ==== tb/sd_link_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sd_link_params.svh"

module sd_link_checker
	import sd_link_pkg::*;
#(
	parameter int MOD_CLK_DIV = `MOD_CLK_DIV_MIN, // System clocks per modulator clock
	parameter int DECIM_RATIO = `DECIM_RATIO      // Bits per word
)
(
	input wire logic    clk_sys_i,               // System clock
	input wire logic    rst_n_i,                 // Reset, active low
	input wire logic    modulator_clock_in,      // Link clock
	input wire logic    modulator_bitstream_out, // Link data
	input wire sample_t sample_o,                // Word
	input wire logic    sample_valid_o,          // Word present
	input wire logic    sample_ready_i           // Word taken
);

	int held;
	int rises;
	int gap;
	int idle;

	// Held: cycles without a clock change; gap: clock rises since the last word appeared
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			held  <= 0;
			rises <= 0;
			gap   <= 0;
			idle  <= 0;
		end
		else
		begin
			held  <= $changed(modulator_clock_in) ? 0 : held + 1;
			rises <= rises + int'($rose(modulator_clock_in));
			gap   <= $rose(sample_valid_o) ? 0 : gap + int'($rose(modulator_clock_in));
			idle  <= (sample_valid_o && !sample_ready_i) ? idle + 1 : 0;
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_bit_on_rise: assert property ($changed(modulator_bitstream_out) |->
		$past(modulator_clock_in) && !$past(modulator_clock_in, 2)) else $error("Bit moved off a clock rise");
	a_bit_stands: assert property ($changed(modulator_bitstream_out) |=>
		$stable(modulator_bitstream_out)) else $error("Bit did not stand");
	// The held count trails a released stall by two edges, so a buffer emptied this cycle is judged next cycle
	a_clk_keeps_running: assert property (!sample_valid_o && !$past(sample_valid_o) |->
		held <= MOD_CLK_DIV) else $error("Clock stopped with room in buffer");
	a_word_holds: assert property (sample_valid_o && !sample_ready_i |=>
		sample_valid_o && $stable(sample_o)) else $error("Word dropped before taken");
	a_first_word_late: assert property (sample_valid_o |-> rises > 3 * DECIM_RATIO)
		else $error("Word before filter filled");
	// The rise that completes a word reaches the gap count only at the edge where the word shows
	a_word_spacing: assert property ($rose(sample_valid_o) |->
		gap + int'($rose(modulator_clock_in)) >= DECIM_RATIO) else $error("Words too close");
	a_word_rate: assert property (!sample_valid_o && rises > 5 * DECIM_RATIO |->
		gap <= 2 * DECIM_RATIO) else $error("Word overdue");
	a_stall_full: assert property (idle > 2 * DECIM_RATIO * MOD_CLK_DIV + 16 |->
		$stable(modulator_clock_in)) else $error("Clock ran with buffer full");

endmodule // sd_link_checker

`default_nettype wire

// ==== tb/sigma_delta_bitstream_decimator_bench.sv ====
`timescale 1ns/100ps
`default_nettype none

module sigma_delta_bitstream_decimator_bench;
	import sd_link_pkg::*;

	localparam int DIV = 2;
	localparam int DR  = 64; // Twice the shortest ratio that keeps the 16-bit scale exact
	localparam int LIM = 8 * DR * DIV;

	logic     clk_sys_i;
	logic     rst_n_i;
	diff_mv_t diff_mv_i;
	sample_t  sample_o;
	logic     sample_valid_o;
	logic     sample_ready_i;
	int       n_errors;
	int       tests_run;
	int       ones;
	sample_t  w;
	// Input, code, code tolerance, ones per DR bits, its tolerance
	diff_mv_t row_mv[5]   = '{16'h0000, 16'h00fa, 16'hff06, 16'h0140, 16'hfec0};
	sample_t  row_code[5] = '{16'h8000, 16'he400, 16'h1c00, 16'hffff, 16'h0000};
	sample_t  row_ctol[5] = '{16'h0200, 16'h0200, 16'h0200, 16'h0000, 16'h0000};
	sample_t  row_ones[5] = '{16'h0020, 16'h0039, 16'h0007, 16'h0040, 16'h0000};
	sample_t  row_otol[5] = '{16'h0002, 16'h0002, 16'h0002, 16'h0000, 16'h0000};

	sd_link_if link();

	sd_modulator_end sd_modulator_end_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link),
		.diff_mv_i(diff_mv_i));

	sd_decimator_end #(.MOD_CLK_DIV(DIV), .DECIM_RATIO(DR)) sd_decimator_end_i (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .link(link), .sample_o(sample_o), .sample_valid_o(sample_valid_o),
		.sample_ready_i(sample_ready_i));

	sd_link_checker #(.MOD_CLK_DIV(DIV), .DECIM_RATIO(DR)) sd_link_checker_i (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .modulator_clock_in(link.modulator_clock_in),
		.modulator_bitstream_out(link.modulator_bitstream_out), .sample_o(sample_o),
		.sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	task automatic finish_test();
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input sample_t seen, input sample_t exp, input sample_t tol);
		tests_run++;
		if ($isunknown(seen) || ((seen > exp) ? seen - exp : exp - seen) > tol)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// The leading edge keeps ready from being driven twice in one time step between handshakes
	task automatic take(output sample_t v);
		int i;
		i = 0;
		@(negedge clk_sys_i);
		while (sample_valid_o !== 1'b1 && i < LIM)
		begin
			@(negedge clk_sys_i);
			i++;
		end
		if (sample_valid_o !== 1'b1)
		begin
			n_errors++;
			finish_test();
		end
		v = sample_o;
		sample_ready_i = 1'b1;
		@(negedge clk_sys_i);
		sample_ready_i = 1'b0;
	endtask

	// Reads one bit per link period, the consumer keeping the buffer empty
	task automatic count(output int n);
		int r;
		logic p;
		@(negedge clk_sys_i);
		n = 0;
		r = 0;
		p = link.modulator_clock_in;
		sample_ready_i = 1'b1;
		for (int c = 0; c < LIM && r < DR; c++)
		begin
			@(negedge clk_sys_i);
			if (link.modulator_clock_in && !p)
			begin
				r++;
				n += int'(link.modulator_bitstream_out);
			end
			p = link.modulator_clock_in;
		end
		sample_ready_i = 1'b0;
		if (r < DR)
		begin
			n_errors++;
			finish_test();
		end
	endtask

	initial
	begin
		diff_mv_i = '0;
		sample_ready_i = 1'b0;
		rst_n_i = 1'b0;
		n_errors = 0;
		tests_run = 0;
		repeat (6) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			diff_mv_i = row_mv[k];
			repeat (5) take(w);
			check(w, row_code[k], row_ctol[k]);
			count(ones);
			check(sample_t'(ones), row_ones[k], row_otol[k]);
		end
		// Full buffer: words must survive a long stall
		diff_mv_i = 16'h0140;
		repeat (4) take(w);
		repeat (LIM) @(negedge clk_sys_i);
		take(w);
		check(w, 16'hffff, 16'h0000);
		check(sample_t'(sample_valid_o), 16'h0001, 16'h0000);
		take(w);
		check(w, 16'hffff, 16'h0000);
		rst_n_i = 1'b0;
		@(negedge clk_sys_i);
		check(sample_t'(sample_valid_o), 16'h0000, 16'h0000);
		check(sample_o, 16'h0000, 16'h0000);
		repeat (5) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		take(w);
		check(w, 16'hffff, 16'h0000);
		finish_test();
	end

endmodule // sigma_delta_bitstream_decimator_bench

`default_nettype wire
